// *** dv/igr_bus_model.sv ***
// Other bus master sharing the pulled-up two-wire lines with the block
`timescale 1ns/1ns
module igr_bus_model (
	input wire logic clock,
	input wire logic scl_oe,
	input wire logic sda_oe,
	output logic scl_line,
	output logic sda_line
);
	logic m_scl_low = 1'b0; // Other master pulls clock low
	logic m_sda_low = 1'b0; // Other master pulls data low
	// ==========================================
	// Wired-AND lines with pull-ups
	// ==========================================
	assign scl_line = !(scl_oe || m_scl_low);
	assign sda_line = !(sda_oe || m_sda_low);
	// Half a bus bit: slow enough for the two-flop input sync
	task automatic half();
		repeat (8) @(posedge clock);
		#1;
	endtask
	// Start, eight bits MSB first, released ninth bit, stop
	task automatic send_byte(input logic [7:0] b);
		m_sda_low = 1'b1;
		half();
		m_scl_low = 1'b1;
		for (int i = 7; i >= -1; i--)
		begin
			m_sda_low = (i >= 0) ? !b[i] : 1'b0;
			half();
			m_scl_low = 1'b0;
			half();
			m_scl_low = 1'b1;
		end
		m_sda_low = 1'b1;
		half();
		m_scl_low = 1'b0;
		half();
		m_sda_low = 1'b0;
		half();
	endtask
endmodule

// *** dv/igr_top_properties.sv ***
// Port checker for general call recognition and repeated start generation
`timescale 1ns/1ns
module igr_top_properties (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_oe,
	input wire logic scl_oe,
	input wire logic ctrl2_wr,
	input wire logic buf_wr,
	input wire logic [7:0] port_control_two,
	input wire logic [7:0] port_data_buffer,
	input wire logic buffer_full_flag,
	input wire logic port_interrupt_flag,
	input wire logic update_address_flag,
	input wire logic start_flag,
	input wire logic write_collision_flag,
	input wire logic bus_collision_flag,
	input wire logic gen_call_hit
);
	// ==========================================
	// Shared clocking and step sequences
	// ==========================================
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	// Enable bit dropped without a collision: normal end of sequence
	sequence rs_done;
		$fell(port_control_two[1]) && !bus_collision_flag;
	endsequence
	// Data falls while clock stays high on the resolved lines
	sequence bus_start;
		$past(scl_in) && scl_in && $fell(sda_in);
	endsequence
	// Refused access while the sequencer still runs
	sequence busy_buf_write;
		buf_wr && port_control_two[1];
	endsequence
	// ==========================================
	// Assertions
	// ==========================================
	chk_rs_drive: assert property ($rose(port_control_two[1]) |-> ##[0:2] scl_oe)
		else $error("clock line not pulled low after request");
	chk_rs_flag: assert property (rs_done |-> ##[0:1] port_interrupt_flag)
		else $error("no interrupt at end of repeated start");
	chk_rs_hold: assert property (rs_done |-> sda_oe)
		else $error("data line not held low after repeated start");
	chk_write_collision_flag_set: assert property (busy_buf_write |=> write_collision_flag)
		else $error("write collision not flagged");
	chk_buf_keep: assert property (busy_buf_write |=> $stable(port_data_buffer))
		else $error("buffer changed by refused write");
	chk_lock_low: assert property (ctrl2_wr && port_control_two[1] |=>
		$stable(port_control_two[4:2]) && $stable(port_control_two[0]))
		else $error("locked control bits changed");
	chk_gc_load: assert property ($rose(gen_call_hit) |-> port_control_two[7] ##[0:1]
		(buffer_full_flag && port_data_buffer == 8'h00))
		else $error("general call match without load or enable");
	chk_gc_flag: assert property ($rose(gen_call_hit) |-> ##[1:60]
		(port_interrupt_flag && !update_address_flag))
		else $error("general call interrupt missing or address update set");
	chk_start_seen: assert property (bus_start |-> ##[1:4] start_flag)
		else $error("start condition not reported");
endmodule
bind igr_top igr_top_properties u_chk (.clock, .reset_n, .scl_in, .sda_in, .sda_oe, .scl_oe,
	.ctrl2_wr, .buf_wr, .port_control_two, .port_data_buffer, .buffer_full_flag,
	.port_interrupt_flag, .update_address_flag, .start_flag, .write_collision_flag,
	.bus_collision_flag, .gen_call_hit);

// *** dv/tb_igr_top.sv ***
// Self-checking bench for general call and repeated start block
`timescale 1ns/1ns
module tb_igr_top;
	logic clock, reset_n, ten_bit_mode, ctrl2_wr, buf_wr, buf_rd, clr_int, clr_write_collision_flag, clr_ua, clr_bcol;
	logic [7:0] own_address_or_baud_reg, ctrl2_wdata, buf_wdata, port_control_two, port_data_buffer;
	logic scl_in, sda_in, scl_oe, sda_oe, buffer_full_flag, port_interrupt_flag, update_address_flag;
	logic start_flag, write_collision_flag, bus_collision_flag, gen_call_hit, en, scl_o, sda_o;
	logic [7:0] b;
	int bad_count = 0, n_tests = 0, cyc = 0, wait_n, generator_period, el;
	// ==========================================
	// Design, far-side master and clock
	// ==========================================
	igr_top dut (.clock, .reset_n, .scl_in, .sda_in, .scl_oe, .sda_oe,
		.scl_out(scl_o), .sda_out(sda_o),
		.ten_bit_mode, .own_address_or_baud_reg, .ctrl2_wr, .ctrl2_wdata, .buf_wr, .buf_wdata,
		.buf_rd, .clr_int, .clr_write_collision_flag, .clr_ua, .clr_bcol, .port_control_two, .port_data_buffer,
		.buffer_full_flag, .port_interrupt_flag, .update_address_flag, .start_flag,
		.write_collision_flag, .bus_collision_flag, .gen_call_hit);
	igr_bus_model bus (.clock, .scl_oe, .sda_oe, .scl_line(scl_in), .sda_line(sda_in));
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// Hang guard, well above the under two thousand cycles the run needs
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			bad_count++;
			test_done();
		end
	end
	// ==========================================
	// Tasks and expectation functions
	// ==========================================
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string nm);
		n_tests++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wr_ctrl(input logic [7:0] d);
		ctrl2_wdata = d;
		ctrl2_wr = 1'b1;
		tick(1);
		ctrl2_wr = 1'b0;
	endtask
	task automatic clr_all();
		{buf_rd, clr_int, clr_write_collision_flag, clr_ua, clr_bcol} = 5'h1f;
		tick(1);
		{buf_rd, clr_int, clr_write_collision_flag, clr_ua, clr_bcol} = 5'h00;
		tick(1);
	endtask
	// Bounded wait for the enable bit to self-clear
	task automatic wait_rs();
		wait_n = 0;
		while (port_control_two[1] === 1'b1 && wait_n < 4000)
		begin
			tick(1);
			wait_n++;
		end
	endtask
	// Bounded wait for the clock pull-down to reach a level
	task automatic wait_oe(input logic v);
		wait_n = 0;
		while (scl_oe !== v && wait_n < 400)
		begin
			tick(1);
			wait_n++;
		end
	endtask
	// Interrupt expected only for the all-zero byte with enable set
	function automatic logic gc_expect(input logic [7:0] a, input logic e);
		return e && (a == 8'h00);
	endfunction
	// Three generator periods, each value plus one ticks of four clocks
	function automatic int rs_cycles(input int v);
		return 3 * (v + 1) * 4;
	endfunction
	// ==========================================
	// Main sequence
	// ==========================================
	initial
	begin
		{reset_n, ten_bit_mode, ctrl2_wr, buf_wr, buf_rd, clr_int, clr_write_collision_flag, clr_ua, clr_bcol} = 9'h000;
		{ctrl2_wdata, buf_wdata} = 16'h0000;
		own_address_or_baud_reg = 8'hfe;
		void'($urandom(54));
		tick(5);
		reset_n = 1'b1;
		tick(1);
		// Random non-matching bytes, then general call disabled and enabled
		for (int k = 0; k < 5; k++)
		begin
			b = (k < 3) ? 8'($urandom_range(2, 253)) & 8'hfe : 8'h00;
			en = (k < 3) ? 1'($urandom_range(0, 1)) : (k == 4);
			ten_bit_mode = (k == 4);
			wr_ctrl({en, 7'h00});
			// Start flag is looked at mid-byte, since the closing stop clears it
			fork
				bus.send_byte(b);
				begin
					tick(24);
					check(8'(start_flag), 8'h01, "start seen");
				end
			join
			tick(4);
			check(8'(port_interrupt_flag), 8'(gc_expect(b, en)), "interrupt flag");
			if (gc_expect(b, en))
			begin
				check({port_data_buffer[7:1], buffer_full_flag}, 8'h01, "buffer and full");
				check(8'(update_address_flag), 8'h00, "update address");
				check(8'(gen_call_hit), 8'h01, "general call source");
			end
			clr_all();
		end
		// Ten-bit first half matching the upper own address bits
		ten_bit_mode = 1'b1;
		bus.send_byte(8'hf6);
		tick(4);
		check(8'(update_address_flag), 8'h01, "update address set");
		clr_all();
		ten_bit_mode = 1'b0;
		// Repeated start with refused buffer and control writes in flight
		generator_period = $urandom_range(1, 6);
		own_address_or_baud_reg = 8'(generator_period);
		wr_ctrl(8'h82);
		tick(2);
		buf_wdata = 8'($urandom_range(1, 255));
		buf_wr = 1'b1;
		tick(1);
		buf_wr = 1'b0;
		wr_ctrl(8'h9d);
		check({3'h0, port_control_two[4:0]}, 8'h02, "locked low bits");
		wait_rs();
		el = 4 + wait_n;
		check(8'(el >= rs_cycles(generator_period) && el <= rs_cycles(generator_period) + 40), 8'h01, "length");
		tick(1);
		check(port_control_two, 8'h80, "control after sequence");
		check(8'(port_interrupt_flag), 8'h01, "sequence interrupt");
		check(8'(sda_oe), 8'h01, "data held low");
		check(8'(write_collision_flag), 8'h01, "write collision");
		check(port_data_buffer, 8'h00, "buffer kept");
		check(8'({scl_o, sda_o}), 8'h00, "pin out levels");
		// Once the start is over, software loads the first address byte
		clr_all();
		buf_wr = 1'b1;
		tick(1);
		buf_wr = 1'b0;
		tick(1);
		check(port_data_buffer, buf_wdata, "buffer after start");
		check(8'(write_collision_flag), 8'h00, "no collision when idle");
		// Second reset, then another master holds data low during the sequence
		reset_n = 1'b0;
		tick(5);
		reset_n = 1'b1;
		tick(1);
		bus.m_sda_low = 1'b1;
		wr_ctrl(8'h02);
		wait_rs();
		// Release only with the clock high, so a stop ends the address phase
		tick(4);
		bus.m_sda_low = 1'b0;
		tick(1);
		check(8'(bus_collision_flag), 8'h01, "bus collision");
		check(port_control_two, 8'h00, "control after collision");
		// Other master pulls data low just as the clock line is released
		clr_all();
		wr_ctrl(8'h02);
		wait_oe(1'b1);
		wait_oe(1'b0);
		bus.m_sda_low = 1'b1;
		tick(8);
		bus.m_sda_low = 1'b0;
		tick(4);
		check(8'(bus_collision_flag), 8'h01, "collision at clock rise");
		// Other master pulls the clock low before the data line falls
		clr_all();
		wr_ctrl(8'h02);
		wait_oe(1'b1);
		wait_oe(1'b0);
		tick(3);
		bus.m_scl_low = 1'b1;
		tick(8);
		bus.m_scl_low = 1'b0;
		tick(4);
		check(8'(bus_collision_flag), 8'h01, "collision at clock fall");
		check(port_control_two, 8'h00, "control after clock fall");
		test_done();
	end
endmodule

// *** hdl/igr_pkg.sv ***
// Package with constants and carriers for the general call and repeated start block
package igr_pkg;
	// ==========================================
	// Field positions and reset values
	// ==========================================
	localparam int GC_EN_BIT = 7; // General call enable in control two
	localparam int RS_EN_BIT = 1; // Repeated start enable in control two
	localparam int UA_BIT = 1; // Update address in status
	localparam int START_BIT = 3; // Start detected in status
	localparam int LOCK_BITS = 5; // Low control bits locked during sequence
	localparam logic [7:0] GC_ADDR = 8'h00; // Fixed general call address byte
	localparam logic [7:0] CTRL2_RESET = 8'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [6:0] BRG_RESET = 7'h00;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8; // Address bits before acknowledge
	localparam logic [3:0] ACK_BIT = 4'h9; // Acknowledge bit number
	localparam logic [1:0] TICK_DIV = 2'h3; // Generator tick every four clocks

	// Repeated start sequencer
	typedef enum logic [2:0] {
		IGR_IDLE = 3'b000,
		IGR_SCL_LOW = 3'b001,
		IGR_SDA_HIGH = 3'b010,
		IGR_SCL_REL = 3'b011,
		IGR_BOTH_HIGH = 3'b100,
		IGR_SDA_LOW = 3'b101
	} igr_rs_e;

	// Synchronised bus lines
	typedef struct packed {
		logic scl;
		logic sda;
	} igr_bus_s;
endpackage

// *** hdl/igr_top.sv ***
// General call recognition and repeated start generation for a two-wire port
`timescale 1ns/1ns
module igr_top #(
	parameter int BRG_W = 7
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic scl_in, // Bus clock line level
	input wire logic sda_in, // Bus data line level
	output logic scl_oe, // High while pulling clock line low
	output logic sda_oe, // High while pulling data line low
	output logic scl_out, // Always zero when driving
	output logic sda_out, // Always zero when driving
	input wire logic ten_bit_mode, // Slave uses ten-bit addressing
	input wire logic [7:0] own_address_or_baud_reg, // Own address or baud reload
	input wire logic ctrl2_wr, // Write strobe for control two
	input wire logic [7:0] ctrl2_wdata,
	input wire logic buf_wr, // Write strobe for data buffer
	input wire logic [7:0] buf_wdata,
	input wire logic buf_rd, // Read of buffer clears full flag
	input wire logic clr_int, // Software clears interrupt flag
	input wire logic clr_write_collision_flag, // Software clears write collision
	input wire logic clr_ua, // Software clears update address
	input wire logic clr_bcol, // Software clears bus collision
	output logic [7:0] port_control_two,
	output logic [7:0] port_data_buffer,
	output logic buffer_full_flag,
	output logic port_interrupt_flag,
	output logic update_address_flag,
	output logic start_flag,
	output logic write_collision_flag,
	output logic bus_collision_flag,
	output logic gen_call_hit // Last address was a general call
);
	// ==========================================
	// Input synchronisers
	// ==========================================
	igr_pkg::igr_bus_s meta_reg;
	igr_pkg::igr_bus_s bus_reg;
	igr_pkg::igr_bus_s prev_reg;

	// Two stages before any logic reads the pins
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			meta_reg <= '{scl: 1'b1, sda: 1'b1};
			bus_reg <= '{scl: 1'b1, sda: 1'b1};
			prev_reg <= '{scl: 1'b1, sda: 1'b1};
		end
		else
		begin
			meta_reg <= '{scl: scl_in, sda: sda_in};
			bus_reg <= meta_reg;
			prev_reg <= bus_reg;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	assign scl_rise = bus_reg.scl && !prev_reg.scl;
	assign scl_fall = !bus_reg.scl && prev_reg.scl;
	// Data falling while clock high is a start
	assign start_cond = bus_reg.scl && prev_reg.scl && !bus_reg.sda && prev_reg.sda;
	assign stop_cond = bus_reg.scl && prev_reg.scl && bus_reg.sda && !prev_reg.sda;

	// ==========================================
	// Generator tick divider and down counter
	// ==========================================
	logic [1:0] div_reg;
	logic tick;
	assign tick = (div_reg == igr_pkg::TICK_DIV);

	// Free running divider for the count tick
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			div_reg <= 2'h0;
		else
			div_reg <= div_reg + 2'h1;
	end

	igr_pkg::igr_rs_e rs_reg;
	logic [BRG_W-1:0] brg_reg;
	logic brg_load;
	logic [BRG_W-1:0] brg_value;
	logic brg_timeout;
	// Timeout when zero is reached on a tick
	assign brg_timeout = tick && (brg_reg == '0) && (rs_reg != igr_pkg::IGR_IDLE);

	// Count down per tick, reload on request
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			brg_reg <= BRG_W'(igr_pkg::BRG_RESET);
		else if (brg_load)
			brg_reg <= brg_value;
		else if (tick && brg_reg != '0)
			brg_reg <= brg_reg - 1'b1;
	end

	// ==========================================
	// Repeated start sequencer
	// ==========================================
	logic slave_busy;
	logic rs_done;
	logic rs_abort;
	logic rs_req;
	// Only accepted with nothing else going on
	assign rs_req = ctrl2_wr && ctrl2_wdata[igr_pkg::RS_EN_BIT] && !slave_busy
		&& rs_reg == igr_pkg::IGR_IDLE;
	assign rs_done = (rs_reg == igr_pkg::IGR_SDA_LOW) && brg_timeout;

	// Reload choices per phase
	always_comb
	begin
		brg_load = 1'b0;
		brg_value = '0;
		if (rs_reg == igr_pkg::IGR_SCL_LOW && !bus_reg.scl)
		begin
			brg_load = 1'b1;
			brg_value = BRG_W'(own_address_or_baud_reg[5:0]);
		end
		else if (rs_reg == igr_pkg::IGR_SCL_REL && bus_reg.scl)
		begin
			brg_load = 1'b1;
			brg_value = BRG_W'(own_address_or_baud_reg[6:0]);
		end
		else if (rs_reg == igr_pkg::IGR_BOTH_HIGH && brg_timeout)
		begin
			brg_load = 1'b1;
			brg_value = BRG_W'(own_address_or_baud_reg[6:0]);
		end
	end

	// Collision checks while sequencing
	always_comb
	begin
		rs_abort = 1'b0;
		if ((rs_reg == igr_pkg::IGR_SCL_REL || rs_reg == igr_pkg::IGR_BOTH_HIGH)
			&& scl_rise && !bus_reg.sda)
			rs_abort = 1'b1;
		else if (rs_reg == igr_pkg::IGR_BOTH_HIGH && scl_fall)
			rs_abort = 1'b1;
		else if (rs_reg == igr_pkg::IGR_SDA_HIGH && brg_timeout && !bus_reg.sda)
			rs_abort = 1'b1;
	end

	// Phase stepping
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			rs_reg <= igr_pkg::IGR_IDLE;
		else if (rs_abort)
			rs_reg <= igr_pkg::IGR_IDLE;
		else
		begin
			case (rs_reg)
				igr_pkg::IGR_IDLE:
					if (rs_req)
						rs_reg <= igr_pkg::IGR_SCL_LOW;
				igr_pkg::IGR_SCL_LOW:
					if (!bus_reg.scl)
						rs_reg <= igr_pkg::IGR_SDA_HIGH;
				igr_pkg::IGR_SDA_HIGH:
					if (brg_timeout && bus_reg.sda)
						rs_reg <= igr_pkg::IGR_SCL_REL;
				igr_pkg::IGR_SCL_REL:
					if (bus_reg.scl)
						rs_reg <= igr_pkg::IGR_BOTH_HIGH;
				igr_pkg::IGR_BOTH_HIGH:
					if (brg_timeout)
						rs_reg <= igr_pkg::IGR_SDA_LOW;
				igr_pkg::IGR_SDA_LOW:
					if (brg_timeout)
						rs_reg <= igr_pkg::IGR_IDLE;
				default:
					rs_reg <= igr_pkg::IGR_IDLE;
			endcase
		end
	end

	logic sda_hold_reg;
	// Data stays low after the start until a stop, a new request or a collision releases it
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			sda_hold_reg <= 1'b0;
		else if (rs_done)
			sda_hold_reg <= 1'b1;
		else if (rs_req || rs_abort || stop_cond)
			sda_hold_reg <= 1'b0;
	end

	// Pin drivers, registered
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end
		else
		begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
			scl_oe <= (rs_reg == igr_pkg::IGR_SCL_LOW || rs_reg == igr_pkg::IGR_SDA_HIGH)
				&& !rs_abort;
			sda_oe <= (rs_reg == igr_pkg::IGR_SDA_LOW && !rs_abort) || sda_hold_reg;
		end
	end

	// ==========================================
	// Slave address receiver
	// ==========================================
	logic [7:0] rx_shift_register;
	logic [3:0] bit_cnt_reg;
	logic addr_phase_reg;
	logic second_half_reg;
	logic gc_match;
	logic own_match;
	logic [7:0] shifted;
	assign shifted = {rx_shift_register[6:0], bus_reg.sda};
	assign slave_busy = (bit_cnt_reg != 4'h0) && addr_phase_reg;
	assign gc_match = (shifted == igr_pkg::GC_ADDR)
		&& port_control_two[igr_pkg::GC_EN_BIT] && !second_half_reg;
	assign own_match = second_half_reg ? (shifted == own_address_or_baud_reg)
		: ten_bit_mode ? (shifted[7:3] == 5'b11110
			&& shifted[2:1] == own_address_or_baud_reg[2:1])
		: (shifted[7:1] == own_address_or_baud_reg[7:1]);

	logic matched_reg;
	// Count and shift on clock rises after a start
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rx_shift_register <= igr_pkg::BYTE_RESET;
			bit_cnt_reg <= 4'h0;
			addr_phase_reg <= 1'b0;
			second_half_reg <= 1'b0;
			matched_reg <= 1'b0;
		end
		else if (start_cond)
		begin
			bit_cnt_reg <= 4'h0;
			addr_phase_reg <= 1'b1;
			matched_reg <= 1'b0;
		end
		else if (stop_cond)
		begin
			addr_phase_reg <= 1'b0;
			second_half_reg <= 1'b0;
			bit_cnt_reg <= 4'h0;
		end
		else if (scl_rise && addr_phase_reg)
		begin
			rx_shift_register <= shifted;
			bit_cnt_reg <= bit_cnt_reg + 4'h1;
			if (bit_cnt_reg == igr_pkg::BITS_PER_BYTE - 4'h1)
				matched_reg <= gc_match || own_match;
		end
		else if (scl_fall && bit_cnt_reg == igr_pkg::ACK_BIT)
		begin
			bit_cnt_reg <= 4'h0;
			// Ten-bit first half waits for second, general call does not
			second_half_reg <= ten_bit_mode && matched_reg && !gen_call_hit
				&& !second_half_reg;
			addr_phase_reg <= ten_bit_mode && matched_reg && !gen_call_hit
				&& !second_half_reg;
		end
	end

	logic last_bit;
	logic ack_fall;
	assign last_bit = scl_rise && addr_phase_reg && !start_cond && !stop_cond
		&& bit_cnt_reg == igr_pkg::BITS_PER_BYTE - 4'h1;
	assign ack_fall = scl_fall && bit_cnt_reg == igr_pkg::ACK_BIT && matched_reg
		&& !start_cond && !stop_cond;

	// Source of last address match
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			gen_call_hit <= 1'b0;
		else if (last_bit)
			gen_call_hit <= gc_match;
	end

	// ==========================================
	// Software visible registers and flags
	// ==========================================
	// Control two with lock of low bits during sequence
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			port_control_two <= igr_pkg::CTRL2_RESET;
		else
		begin
			if (ctrl2_wr)
			begin
				port_control_two[7:igr_pkg::LOCK_BITS] <= ctrl2_wdata[7:igr_pkg::LOCK_BITS];
				if (rs_reg == igr_pkg::IGR_IDLE)
					port_control_two[igr_pkg::LOCK_BITS-1:0] <= ctrl2_wdata[4:0];
			end
			// Start bit only kept if the request was taken
			if (ctrl2_wr && ctrl2_wdata[igr_pkg::RS_EN_BIT] && !rs_req)
				port_control_two[igr_pkg::RS_EN_BIT] <= port_control_two[igr_pkg::RS_EN_BIT];
			if (rs_done || rs_abort)
				port_control_two[igr_pkg::RS_EN_BIT] <= 1'b0;
		end
	end

	// Buffer loads from receiver or software
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			port_data_buffer <= igr_pkg::BYTE_RESET;
		else if (last_bit && gc_match)
			port_data_buffer <= shifted;
		else if (buf_wr && rs_reg == igr_pkg::IGR_IDLE)
			port_data_buffer <= buf_wdata;
	end

	// Sticky flags, set wins over clear
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			buffer_full_flag <= 1'b0;
			port_interrupt_flag <= 1'b0;
			update_address_flag <= 1'b0;
			start_flag <= 1'b0;
			write_collision_flag <= 1'b0;
			bus_collision_flag <= 1'b0;
		end
		else
		begin
			if (last_bit && gc_match)
				buffer_full_flag <= 1'b1;
			else if (buf_rd)
				buffer_full_flag <= 1'b0;
			if (ack_fall || rs_done)
				port_interrupt_flag <= 1'b1;
			else if (clr_int)
				port_interrupt_flag <= 1'b0;
			if (ack_fall && ten_bit_mode && !gen_call_hit && !second_half_reg)
				update_address_flag <= 1'b1;
			else if (clr_ua)
				update_address_flag <= 1'b0;
			if (start_cond)
				start_flag <= 1'b1;
			else if (stop_cond)
				start_flag <= 1'b0;
			if (buf_wr && rs_reg != igr_pkg::IGR_IDLE)
				write_collision_flag <= 1'b1;
			else if (clr_write_collision_flag)
				write_collision_flag <= 1'b0;
			if (rs_abort)
				bus_collision_flag <= 1'b1;
			else if (clr_bcol)
				bus_collision_flag <= 1'b0;
		end
	end
endmodule
